// File: rtl/qpd_defines.svh
`ifndef QPD_DEFINES_SVH
`define QPD_DEFINES_SVH

// Register byte offsets
`define QPD_CTRL_OFFSET      8'h00
`define QPD_TOP_OFFSET       8'h04
`define QPD_POS_OFFSET       8'h08
`define QPD_STATUS_OFFSET    8'h0c
`define QPD_FIFO_OFFSET      8'h10
`define QPD_TAG_OFFSET       8'h14

// Control field positions
`define QPD_CTRL_CLEAR_BIT   0
`define QPD_CTRL_PERMIT_BIT  2

// Status field positions
`define QPD_STAT_ERR_BIT     0
`define QPD_STAT_CAP_BIT     1
`define QPD_STAT_DIR_BIT     2
`define QPD_STAT_EMPTY_BIT   3
`define QPD_STAT_FULL_BIT    4

// Reset values
`define QPD_CTRL_RESET       32'h0000_0000
`define QPD_TOP_RESET        32'hffff_ffff

// Interrupt tags
`define QPD_TAG_ERROR        8'h0b
`define QPD_TAG_CAPTURE      8'h05

`endif

// File: rtl/qpd_pkg.sv
package qpd_pkg;
    typedef logic [1:0] qpd_phase_type;
    typedef enum logic [1:0] {
        QPD_MOVE_NONE,
        QPD_MOVE_FWD,
        QPD_MOVE_REV,
        QPD_MOVE_BAD
    } qpd_move_type;
endpackage : qpd_pkg

// File: rtl/qpd_decoder.sv
// Chosen here: the placing of the registers and register access over AHB-Lite.
`include "qpd_defines.svh"

module qpd_decoder #(
    parameter int FIFO_DEPTH = 4
) (
    // Clock and reset
    input  wire logic         hclk,
    input  wire logic         hresetn,
    // AHB-Lite slave
    input  wire logic         hsel,
    input  wire logic [31:0]  haddr,
    input  wire logic [1:0]   htrans,
    input  wire logic         hwrite,
    input  wire logic [2:0]   hsize,
    input  wire logic [31:0]  hwdata,
    input  wire logic         hready,
    output logic              hreadyout,
    output logic              hresp,
    output logic [31:0]       hrdata,
    // Encoder pins
    input  wire logic         phase_a,
    input  wire logic         phase_b,
    input  wire logic         index_pulse,
    // Status outputs
    output logic              direction,
    output logic              irq
);
    import qpd_pkg::*;

    localparam int PTR_W = $clog2(FIFO_DEPTH);

    // ************************************************************
    // Input synchronisers
    // ************************************************************
    logic [2:0]    sync_meta;
    logic [2:0]    sync_pins;
    qpd_phase_type prev_phase;
    logic          prev_index;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            sync_meta  <= 3'h0;
            sync_pins  <= 3'h0;
            prev_phase <= 2'h0;
            prev_index <= 1'b0;
        end else begin
            sync_meta  <= {index_pulse, phase_b, phase_a};
            sync_pins  <= sync_meta;
            prev_phase <= sync_pins[1:0];
            prev_index <= sync_pins[2];
        end
    end

    // ************************************************************
    // Transition decode
    // ************************************************************
    function automatic qpd_move_type classify(input qpd_phase_type prev,
                                              input qpd_phase_type cur);
        // Gray order 00 -> 01 -> 11 -> 10 (bit0 = A) is A leading B
        logic [1:0] chg;
        chg = prev ^ cur;
        if (chg == 2'h0)
            return QPD_MOVE_NONE;
        else if (chg == 2'h3)
            return QPD_MOVE_BAD;
        else if ((cur[0] ^ prev[1]) == 1'b1)
            return QPD_MOVE_FWD;
        else
            return QPD_MOVE_REV;
    endfunction : classify

    qpd_move_type move;
    wire          cur_valid;
    wire          err_now;
    wire          index_rise;

    assign move       = classify(prev_phase, sync_pins[1:0]);
    assign cur_valid  = (move == QPD_MOVE_FWD) || (move == QPD_MOVE_REV);
    assign err_now    = (move == QPD_MOVE_BAD);
    assign index_rise = sync_pins[2] & ~prev_index;

    // ************************************************************
    // Registers and bus
    // ************************************************************
    logic [31:0] ctrl;
    logic [31:0] top_position;
    logic [31:0] position;
    logic        err_flag;
    logic        cap_flag;
    logic        err_level;
    logic [7:0]  last_tag;
    logic        dp_write;
    logic        dp_read;
    logic [7:0]  dp_addr;
    logic [31:0] fifo_mem [FIFO_DEPTH];
    logic [PTR_W-1:0] fifo_wp;
    logic [PTR_W-1:0] fifo_rp;
    logic [PTR_W:0]   fifo_cnt;

    wire ap_valid    = hsel & hready & htrans[1];
    wire clear_req   = ctrl[`QPD_CTRL_CLEAR_BIT];
    wire count_permit = ctrl[`QPD_CTRL_PERMIT_BIT];
    wire fifo_empty  = (fifo_cnt == '0);
    wire fifo_full   = (fifo_cnt == (PTR_W+1)'(FIFO_DEPTH));
    wire err_rise    = err_now & ~err_level;
    wire fifo_pop    = dp_read & (dp_addr == `QPD_FIFO_OFFSET) & ~fifo_empty;
    wire fifo_push   = index_rise & ~fifo_full;
    wire wr_ctrl     = dp_write & (dp_addr == `QPD_CTRL_OFFSET);
    wire wr_top      = dp_write & (dp_addr == `QPD_TOP_OFFSET);
    wire wr_status   = dp_write & (dp_addr == `QPD_STATUS_OFFSET);

    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            dp_write <= 1'b0;
            dp_read  <= 1'b0;
            dp_addr  <= 8'h00;
        end else begin
            dp_write <= ap_valid & hwrite & (hsize == 3'h2);
            dp_read  <= ap_valid & ~hwrite;
            dp_addr  <= haddr[7:0];
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl         <= `QPD_CTRL_RESET;
            top_position <= `QPD_TOP_RESET;
        end else begin
            if (wr_ctrl)
                ctrl <= hwdata & 32'h0000_0005;
            if (wr_top)
                top_position <= hwdata;
        end
    end

    // Read data is registered in the address phase for the next cycle
    logic [31:0] next_rdata;
    always_comb begin
        case (haddr[7:0])
            `QPD_CTRL_OFFSET:   next_rdata = ctrl;
            `QPD_TOP_OFFSET:    next_rdata = top_position;
            `QPD_POS_OFFSET:    next_rdata = position;
            `QPD_STATUS_OFFSET: next_rdata = {27'h0, fifo_full, fifo_empty,
                                              direction, cap_flag, err_flag};
            `QPD_FIFO_OFFSET:   next_rdata = fifo_mem[fifo_rp];
            `QPD_TAG_OFFSET:    next_rdata = {24'h0, last_tag};
            default:            next_rdata = 32'h0;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            hrdata <= 32'h0;
        else if (ap_valid & ~hwrite)
            hrdata <= next_rdata;
    end

    // ************************************************************
    // Position counter
    // ************************************************************
    wire top_match  = (position == top_position);
    wire count_step = cur_valid & count_permit & ~clear_req;

    logic [31:0] next_position;
    always_comb begin
        next_position = position;
        if (clear_req || top_match)
            next_position = 32'h0;
        else if (count_step && move == QPD_MOVE_FWD)
            next_position = position + 32'h1;
        else if (count_step)
            next_position = (position == 32'h0) ? top_position - 32'h1
                                                : position - 32'h1;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            position  <= 32'h0;
            direction <= 1'b0;
        end else begin
            position <= next_position;
            if (cur_valid)
                direction <= (move == QPD_MOVE_FWD);
        end
    end

    // ************************************************************
    // Capture FIFO
    // ************************************************************
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            fifo_wp  <= '0;
            fifo_rp  <= '0;
            fifo_cnt <= '0;
        end else begin
            if (fifo_push)
                fifo_wp <= PTR_W'((fifo_wp + 1'b1) % FIFO_DEPTH);
            if (fifo_pop)
                fifo_rp <= PTR_W'((fifo_rp + 1'b1) % FIFO_DEPTH);
            if (fifo_push && !fifo_pop)
                fifo_cnt <= fifo_cnt + 1'b1;
            else if (fifo_pop && !fifo_push)
                fifo_cnt <= fifo_cnt - 1'b1;
        end
    end

    // Storage is not reset; only entries counted by fifo_cnt are meaningful
    always_ff @(posedge hclk) begin
        if (fifo_push)
            fifo_mem[fifo_wp] <= position;
    end

    // ************************************************************
    // Event flags and tags
    // ************************************************************
    // Set wins over a software clear arriving in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            err_level <= 1'b0;
            err_flag  <= 1'b0;
            cap_flag  <= 1'b0;
            last_tag  <= 8'h00;
        end else begin
            err_level <= err_now;
            if (err_rise)
                err_flag <= 1'b1;
            else if (wr_status && hwdata[`QPD_STAT_ERR_BIT])
                err_flag <= 1'b0;
            if (fifo_push)
                cap_flag <= 1'b1;
            else if (wr_status && hwdata[`QPD_STAT_CAP_BIT])
                cap_flag <= 1'b0;
            if (err_rise)
                last_tag <= `QPD_TAG_ERROR;
            else if (fifo_push)
                last_tag <= `QPD_TAG_CAPTURE;
        end
    end

    assign irq = err_flag | cap_flag;

    // ************************************************************
    // Assertions
    // ************************************************************
    a_clear_holds_zero: assert property (@(posedge hclk) disable iff (!hresetn)
        $past(clear_req) |-> position == 32'h0)
        else $error("Counter not held at zero while clear set");
    a_no_count_unpermit: assert property (@(posedge hclk) disable iff (!hresetn)
        (!count_permit && !clear_req && !top_match) |=> $stable(position))
        else $error("Counter moved while counting not permitted");
    a_fwd_step_one: assert property (@(posedge hclk) disable iff (!hresetn)
        (count_step && move == QPD_MOVE_FWD && !top_match)
        |=> position == $past(position) + 32'h1)
        else $error("Forward step not exactly one");
    a_bad_no_count: assert property (@(posedge hclk) disable iff (!hresetn)
        (err_now && !clear_req && !top_match) |=> $stable(position))
        else $error("Invalid transition changed the counter");
    a_top_resets: assert property (@(posedge hclk) disable iff (!hresetn)
        top_match |=> position == 32'h0)
        else $error("Top match did not reset counter");
    a_err_tag_irq: assert property (@(posedge hclk) disable iff (!hresetn)
        err_rise |=> (last_tag == `QPD_TAG_ERROR) && irq && err_flag)
        else $error("Error edge did not raise tag 11");
    a_cap_tag: assert property (@(posedge hclk) disable iff (!hresetn)
        (fifo_push && !err_rise) |=> (last_tag == `QPD_TAG_CAPTURE) && cap_flag)
        else $error("Capture did not raise tag 5");
    a_cap_stores: assert property (@(posedge hclk) disable iff (!hresetn)
        (fifo_push && fifo_empty && !fifo_pop)
        |=> fifo_mem[fifo_rp] == $past(position))
        else $error("Captured value differs from counter");
    a_dir_fwd: assert property (@(posedge hclk) disable iff (!hresetn)
        move == QPD_MOVE_FWD |=> direction)
        else $error("Direction not one on forward move");

endmodule : qpd_decoder

// File: testbench/qpd_enc_model.sv
module qpd_enc_model (
    // Clock
    input  wire logic hclk,
    // Encoder pins
    output logic      phase_a,
    output logic      phase_b,
    output logic      index_pulse
);
    timeunit 1ns;
    timeprecision 1ps;

    logic [1:0] step_idx;
    logic [1:0] gray;

    // Gray order 00,10,11,01: A leads B going forward
    assign gray    = (step_idx == 2'd0) ? 2'b00 : (step_idx == 2'd1) ? 2'b10 :
                     (step_idx == 2'd2) ? 2'b11 : 2'b01;
    assign phase_a = gray[1];
    assign phase_b = gray[0];

    initial begin
        step_idx    = 2'd0;
        index_pulse = 1'b0;
    end

    // Delta 1 forward, 3 reverse, 2 moves both phases at once (a fault)
    // Gap of six cycles leaves room for the two-flop synchroniser
    task automatic move(input logic [1:0] delta, input int n);
        repeat (n) begin
            @(posedge hclk);
            step_idx <= step_idx + delta;
            repeat (6) @(posedge hclk);
        end
    endtask : move

    task automatic mark;
        @(posedge hclk);
        index_pulse <= 1'b1;
        repeat (4) @(posedge hclk);
        index_pulse <= 1'b0;
        repeat (6) @(posedge hclk);
    endtask : mark
endmodule : qpd_enc_model

// File: testbench/tb_top.sv
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;

    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [2:0]  hsize;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic        hresp;
    logic [31:0] hrdata;
    logic        phase_a;
    logic        phase_b;
    logic        index_pulse;
    logic        direction;
    logic        irq;
    int          error_cnt;
    int          compares;

    qpd_decoder #(.FIFO_DEPTH(4)) i_qpd_decoder (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .phase_a(phase_a),
        .phase_b(phase_b), .index_pulse(index_pulse), .direction(direction), .irq(irq)
    );

    qpd_enc_model i_qpd_enc_model (
        .hclk(hclk), .phase_a(phase_a), .phase_b(phase_b), .index_pulse(index_pulse)
    );

    // ****************************************
    // Bus and compare helpers
    // ****************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
        end
    endtask : chk

    // Single word transfer; waits on hready with a bound in both phases
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd,
                       output logic [31:0] rd);
        int n;
        n = 0;
        @(posedge hclk);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        hsize  <= 3'b010;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 100);
        htrans <= 2'b00;
        hwdata <= wd;
        do begin
            @(posedge hclk);
            n++;
        end while (hreadyout !== 1'b1 && n < 200);
        rd = hrdata;
        if (n >= 200) chk(1'b0, 1'b1, "bus hang");
    endtask : bus

    task automatic wr(input logic [31:0] a, input logic [31:0] d);
        logic [31:0] rd;
        bus(1'b1, a, d, rd);
    endtask : wr

    task automatic rdchk(input logic [31:0] a, input logic [31:0] mask,
                         input logic [31:0] exp, input string msg);
        logic [31:0] rd;
        bus(1'b0, a, 32'h0000_0000, rd);
        chk(rd & mask, exp, msg);
    endtask : rdchk

    // ****************************************
    // Scenarios
    // ****************************************
    task automatic t_reset;
        rdchk(32'h00, 32'hffff_ffff, 32'h0000_0000, "ctrl reset");
        rdchk(32'h04, 32'hffff_ffff, 32'hffff_ffff, "top reset");
        rdchk(32'h08, 32'hffff_ffff, 32'h0000_0000, "pos reset");
        rdchk(32'h40, 32'hffff_ffff, 32'h0000_0000, "unmapped read");
        chk(hresp, 1'b0, "okay response");
        $display("test reset done");
    endtask : t_reset

    task automatic t_count;
        wr(32'h00, 32'h0000_0004);
        i_qpd_enc_model.move(2'd1, 8);
        rdchk(32'h08, 32'hffff_ffff, 32'h0000_0008, "forward 4x count");
        chk(direction, 1'b1, "forward direction");
        rdchk(32'h0c, 32'h0000_0004, 32'h0000_0004, "status direction");
        i_qpd_enc_model.move(2'd3, 3);
        rdchk(32'h08, 32'hffff_ffff, 32'h0000_0005, "reverse count");
        chk(direction, 1'b0, "reverse direction");
        $display("test count done");
    endtask : t_count

    task automatic t_control;
        wr(32'h00, 32'h0000_0000);
        i_qpd_enc_model.move(2'd1, 2);
        rdchk(32'h08, 32'hffff_ffff, 32'h0000_0005, "count stopped");
        // Clear wins over permit while both are set
        wr(32'h00, 32'h0000_0005);
        i_qpd_enc_model.move(2'd1, 2);
        rdchk(32'h08, 32'hffff_ffff, 32'h0000_0000, "held in clear");
        wr(32'h00, 32'h0000_0004);
        i_qpd_enc_model.move(2'd1, 1);
        rdchk(32'h08, 32'hffff_ffff, 32'h0000_0001, "released count");
        $display("test control done");
    endtask : t_control

    task automatic t_error;
        chk(irq, 1'b0, "no request yet");
        i_qpd_enc_model.move(2'd2, 1);
        rdchk(32'h08, 32'hffff_ffff, 32'h0000_0001, "no count on fault");
        chk(irq, 1'b1, "fault request");
        rdchk(32'h0c, 32'h0000_0001, 32'h0000_0001, "fault flag");
        rdchk(32'h14, 32'h0000_00ff, 32'h0000_000b, "fault tag");
        wr(32'h0c, 32'h0000_0001);
        // The clear lands on the last edge of the write; let it settle
        @(posedge hclk);
        chk(irq, 1'b0, "fault cleared");
        $display("test error done");
    endtask : t_error

    task automatic t_top;
        wr(32'h04, 32'h0000_0003);
        i_qpd_enc_model.move(2'd1, 2);
        rdchk(32'h08, 32'hffff_ffff, 32'h0000_0000, "wrap at top");
        i_qpd_enc_model.move(2'd1, 1);
        i_qpd_enc_model.move(2'd3, 2);
        rdchk(32'h08, 32'hffff_ffff, 32'h0000_0002, "reverse wrap");
        $display("test top done");
    endtask : t_top

    task automatic t_index;
        i_qpd_enc_model.mark;
        chk(irq, 1'b1, "capture request");
        rdchk(32'h0c, 32'h0000_000a, 32'h0000_0002, "capture flag");
        rdchk(32'h14, 32'h0000_00ff, 32'h0000_0005, "capture tag");
        rdchk(32'h10, 32'hffff_ffff, 32'h0000_0002, "captured value");
        rdchk(32'h0c, 32'h0000_0008, 32'h0000_0008, "fifo empty");
        $display("test index done");
    endtask : t_index

    task automatic conclude;
        $display("Counts: %0d compares, %0d mismatches", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask : conclude

    // ****************************************
    // Clock, reset, sequence, watchdog
    // ****************************************
    initial begin
        hclk = 1'b0;
        forever #2.5 hclk = ~hclk;
    end

    initial begin
        error_cnt = 0;
        compares  = 0;
        hresetn   = 1'b0;
        hsel      = 1'b0;
        haddr     = 32'h0000_0000;
        htrans    = 2'b00;
        hwrite    = 1'b0;
        hsize     = 3'b010;
        hwdata    = 32'h0000_0000;
        repeat (8) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset;
        t_count;
        t_control;
        t_error;
        t_top;
        t_index;
        conclude;
    end

    initial begin
        repeat (20000) @(posedge hclk);
        error_cnt++;
        conclude;
    end
endmodule : tb_top
